/* File: verilog/ogpm_pkg.sv */
package ogpm_pkg;

  // register offsets, one 16-bit register per address
  localparam logic [7:0] ADDR_LOAD_CTRL  = 8'h40;
  localparam logic [7:0] ADDR_GAIN5      = 8'h41;
  localparam logic [7:0] ADDR_FREQ_LOW   = 8'h42;
  localparam logic [7:0] ADDR_FREQ_HIGH  = 8'h43;
  localparam logic [7:0] ADDR_STAGE5_CNT = 8'h44;
  localparam logic [7:0] ADDR_MON_CTRL   = 8'h46;
  localparam logic [7:0] ADDR_TIMER_LOW  = 8'h47;
  localparam logic [7:0] ADDR_TIMER_MID  = 8'h48;
  localparam logic [7:0] ADDR_TIMER_HIGH = 8'h49;
  localparam logic [7:0] ADDR_FINAL_GAIN_SETTING      = 8'h50;
  localparam logic [7:0] ADDR_STAGE6_CNT = 8'h51;

  // widths
  localparam int REG_W       = 16;
  localparam int SAMPLE_W    = 16;
  localparam int GAIN_W      = 9;
  localparam int COUNT_W     = 12;
  localparam int TIMER_W     = 48;
  localparam int FREQ_W      = 21;
  localparam int FREQ_HIGH_W = 5;
  localparam int THRESH_W    = 8;
  localparam int GAIN_FRAC   = 8;
  localparam int NUM_MON     = 2;

  // field positions
  localparam int LOAD_PULSE_BIT = 0;
  localparam int MON_RESET_BIT  = 0;
  localparam int MON_MODE_BIT   = 1;
  localparam int MON_ENABLE_BIT = 2;
  localparam int THRESH_LSB     = 8;

  // reset values
  localparam logic [8:0]  GAIN5_RST   = 9'h0FF;
  localparam logic [8:0]  FINAL_GAIN_SETTING_RST   = 9'h100;
  localparam logic [15:0] REG_ZERO    = 16'h0000;
  localparam logic [11:0] COUNT_MAX   = 12'hFFF;

  // saturation limits of a 16-bit signed sample
  localparam logic signed [26:0] SAT_POS = 27'sh0007FFF;
  localparam logic signed [26:0] SAT_NEG = -27'sh0008000;

  typedef struct packed {
    logic                       valid;
    logic signed [SAMPLE_W-1:0] data;
  } ogpm_sample_s;

  typedef struct packed {
    logic                       enable;
    logic                       above;
    logic signed [THRESH_W-1:0] threshold;
  } ogpm_mon_cfg_s;

endpackage : ogpm_pkg

/* File: verilog/ogpm_gain_stage.sv */
`timescale 1ns/1ps
module ogpm_gain_stage (
  // clock and reset
  input  wire logic                              mclk,
  input  wire logic                              rst,
  // sample path
  input  wire ogpm_pkg::ogpm_sample_s            smp_in,
  input  wire logic [ogpm_pkg::GAIN_W-1:0]       gain,
  output ogpm_pkg::ogpm_sample_s                 smp_out_r
);

  logic signed [26:0] data_ext;
  logic signed [26:0] gain_ext;
  logic signed [26:0] prod;
  logic signed [26:0] scaled;
  logic signed [15:0] sat_nxt;

  // gain is unsigned, so a zero is prepended before widening
  always_comb begin
    data_ext = 27'(smp_in.data);
    gain_ext = 27'($signed({1'b0, gain}));
    prod     = data_ext * gain_ext;
    scaled   = prod >>> ogpm_pkg::GAIN_FRAC;
    if (scaled > ogpm_pkg::SAT_POS) begin
      sat_nxt = ogpm_pkg::SAT_POS[15:0];
    end else if (scaled < ogpm_pkg::SAT_NEG) begin
      sat_nxt = ogpm_pkg::SAT_NEG[15:0];
    end else begin
      sat_nxt = scaled[15:0];
    end
  end

  // one register stage; clipping avoids wrap on large gains
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      smp_out_r <= '0;
    end else begin
      smp_out_r.valid <= smp_in.valid;
      smp_out_r.data  <= sat_nxt;
    end
  end

endmodule : ogpm_gain_stage

/* File: verilog/ogpm_thresh_counter.sv */
`timescale 1ns/1ps
module ogpm_thresh_counter (
  // clock and reset
  input  wire logic                              mclk,
  input  wire logic                              rst,
  // sample and setup
  input  wire ogpm_pkg::ogpm_sample_s            smp,
  input  wire ogpm_pkg::ogpm_mon_cfg_s           cfg,
  input  wire logic                              restart,
  input  wire logic                              window_open,
  // result
  output logic [ogpm_pkg::COUNT_W-1:0]           count_r
);

  logic signed [7:0] smp_top;
  logic              hit;

  // compare the top byte against the signed threshold
  always_comb begin
    smp_top = smp.data[15:8];
    if (cfg.above) begin
      hit = smp_top > cfg.threshold;
    end else begin
      hit = smp_top < cfg.threshold;
    end
  end

  // counter holds at full scale rather than wrapping to a small value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (restart) begin
      count_r <= '0;
    end else if (cfg.enable && window_open && smp.valid && hit &&
                 count_r != ogpm_pkg::COUNT_MAX) begin
      count_r <= count_r + 12'h001;
    end
  end

endmodule : ogpm_thresh_counter

/* File: verilog/ogpm_top.sv */
`timescale 1ns/1ps
module ogpm_top (
  // clock and reset
  input  wire logic                                mclk,
  input  wire logic                                rst,
  // register port
  input  wire logic [7:0]                          reg_addr,
  input  wire logic [ogpm_pkg::REG_W-1:0]          reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic [ogpm_pkg::REG_W-1:0]               reg_rdata_r,
  // sample path
  input  wire ogpm_pkg::ogpm_sample_s              combiner_in,
  output ogpm_pkg::ogpm_sample_s                   final_out,
  // oscillator four frequency
  output logic [ogpm_pkg::FREQ_W-1:0]              osc4_frequency_word_r,
  output logic                                     osc4_freq_sign_r,
  output logic [ogpm_pkg::FREQ_W-2:0]              osc4_freq_magnitude_r,
  output logic signed [ogpm_pkg::FREQ_W-1:0]       osc4_freq_step_r,
  output logic                                     osc4_freq_update_r,
  // monitor state
  output logic                                     monitor_busy_r
);

  // number of watched gain-stage outputs
  localparam int NM = ogpm_pkg::NUM_MON;

  // software registers
  logic [ogpm_pkg::REG_W-1:0]       osc4_freq_word_low_r;
  logic [ogpm_pkg::FREQ_HIGH_W-1:0] osc4_freq_word_high_r;
  logic [ogpm_pkg::GAIN_W-1:0]      stage5_gain_r;
  logic [ogpm_pkg::GAIN_W-1:0]      final_gain_value_r;
  logic [ogpm_pkg::THRESH_W-1:0]    monitor_threshold_r;
  logic                             monitor_enable_r;
  logic                             monitor_above_r;
  logic                             freq_word_load_pulse_r;
  logic                             monitor_restart_r;
  logic [ogpm_pkg::TIMER_W-1:0]     start_count_r;

  // monitor period
  logic [ogpm_pkg::TIMER_W-1:0]     timer_r;
  logic                             window_r;

  // datapath and counts
  ogpm_pkg::ogpm_sample_s           stage5_out;
  ogpm_pkg::ogpm_sample_s           mon_smp [NM];
  ogpm_pkg::ogpm_mon_cfg_s          mon_cfg;
  logic [ogpm_pkg::COUNT_W-1:0]     mon_count [NM];
  logic [ogpm_pkg::REG_W-1:0]       rdata_nxt;
  logic [ogpm_pkg::FREQ_W-1:0]      freq_word_nxt;

  // write hits on the two strobe registers
  logic wr_hit_ctrl;
  logic wr_hit_mon;

  assign wr_hit_ctrl = reg_wr && (reg_addr == ogpm_pkg::ADDR_LOAD_CTRL);
  assign wr_hit_mon  = reg_wr && (reg_addr == ogpm_pkg::ADDR_MON_CTRL);

  // frequency word staging; the oscillator does not see these until loaded
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc4_freq_word_low_r  <= '0;
      osc4_freq_word_high_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ogpm_pkg::ADDR_FREQ_LOW) begin
        osc4_freq_word_low_r <= reg_wdata;
      end else if (reg_addr == ogpm_pkg::ADDR_FREQ_HIGH) begin
        osc4_freq_word_high_r <= reg_wdata[ogpm_pkg::FREQ_HIGH_W-1:0];
      end
    end
  end

  // gain settings; the upper write bits are dropped, both gains are
  // unsigned multipliers with eight fraction bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage5_gain_r      <= ogpm_pkg::GAIN5_RST;
      final_gain_value_r <= ogpm_pkg::FINAL_GAIN_SETTING_RST;
    end else if (reg_wr) begin
      if (reg_addr == ogpm_pkg::ADDR_GAIN5) begin
        stage5_gain_r <= reg_wdata[ogpm_pkg::GAIN_W-1:0];
      end else if (reg_addr == ogpm_pkg::ADDR_FINAL_GAIN_SETTING) begin
        final_gain_value_r <= reg_wdata[ogpm_pkg::GAIN_W-1:0];
      end
    end
  end

  // monitor setup; threshold, mode and enable change together in one
  // write, so a half-updated compare is never applied
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      monitor_threshold_r <= '0;
      monitor_enable_r    <= 1'b0;
      monitor_above_r     <= 1'b0;
    end else if (wr_hit_mon) begin
      monitor_threshold_r <= reg_wdata[ogpm_pkg::THRESH_LSB +: ogpm_pkg::THRESH_W];
      monitor_enable_r    <= reg_wdata[ogpm_pkg::MON_ENABLE_BIT];
      monitor_above_r     <= reg_wdata[ogpm_pkg::MON_MODE_BIT];
    end
  end

  // start count; only taken up by the timer on the next restart, so
  // rewriting it mid-period does not disturb a period already running
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      start_count_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ogpm_pkg::ADDR_TIMER_LOW) begin
        start_count_r[15:0] <= reg_wdata;
      end else if (reg_addr == ogpm_pkg::ADDR_TIMER_MID) begin
        start_count_r[31:16] <= reg_wdata;
      end else if (reg_addr == ogpm_pkg::ADDR_TIMER_HIGH) begin
        start_count_r[47:32] <= reg_wdata;
      end
    end
  end

  // load strobe: high for the one cycle after the write, then clears
  // itself, so every new word needs a fresh write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      freq_word_load_pulse_r <= 1'b0;
    end else begin
      freq_word_load_pulse_r <= wr_hit_ctrl && reg_wdata[ogpm_pkg::LOAD_PULSE_BIT];
    end
  end

  // restart strobe: one cycle wide; a period never starts again on its
  // own, software has to write it once more
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      monitor_restart_r <= 1'b0;
    end else begin
      monitor_restart_r <= wr_hit_mon && reg_wdata[ogpm_pkg::MON_RESET_BIT];
    end
  end

  // the 21-bit word as software has staged it
  assign freq_word_nxt = {osc4_freq_word_high_r, osc4_freq_word_low_r};

  // staged words only reach the oscillator on the load pulse, so a
  // half-written word is never seen by the running oscillator
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc4_frequency_word_r <= '0;
      osc4_freq_sign_r      <= 1'b0;
      osc4_freq_magnitude_r <= '0;
    end else if (freq_word_load_pulse_r) begin
      osc4_frequency_word_r <= freq_word_nxt;
      osc4_freq_sign_r      <= freq_word_nxt[ogpm_pkg::FREQ_W-1];
      osc4_freq_magnitude_r <= freq_word_nxt[ogpm_pkg::FREQ_W-2:0];
    end
  end

  // two's complement step for the accumulator; a negative zero in the
  // signed-magnitude word turns into a plain zero step
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc4_freq_step_r <= '0;
    end else if (freq_word_load_pulse_r) begin
      if (freq_word_nxt[ogpm_pkg::FREQ_W-1]) begin
        osc4_freq_step_r <= -$signed({1'b0, freq_word_nxt[ogpm_pkg::FREQ_W-2:0]});
      end else begin
        osc4_freq_step_r <= $signed({1'b0, freq_word_nxt[ogpm_pkg::FREQ_W-2:0]});
      end
    end
  end

  // update strobe follows the new word by the same edge, so a consumer
  // can take the word on the strobe without a further delay
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc4_freq_update_r <= 1'b0;
    end else begin
      osc4_freq_update_r <= freq_word_load_pulse_r;
    end
  end

  // period timer counts clocks while enabled; a zero start count
  // gives an empty period, so nothing is counted until reloaded;
  // with the enable clear the timer waits, so the period only stretches
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer_r  <= '0;
      window_r <= 1'b0;
    end else if (monitor_restart_r) begin
      timer_r  <= start_count_r;
      window_r <= |start_count_r;
    end else if (window_r && monitor_enable_r) begin
      timer_r <= timer_r - 48'h000000000001;
      if (timer_r == 48'h000000000001) begin
        window_r <= 1'b0;
      end
    end
  end

  // busy mirrors the open period for the outside world,
  // one cycle late as it is a registered copy of the window
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      monitor_busy_r <= 1'b0;
    end else begin
      monitor_busy_r <= window_r;
    end
  end

  // fifth stage, then final stage feeding the output;
  // each stage adds one register, so the final output trails by two
  ogpm_gain_stage u_stage5 (
    .mclk      (mclk),
    .rst       (rst),
    .smp_in    (combiner_in),
    .gain      (stage5_gain_r),
    .smp_out_r (stage5_out)
  );

  ogpm_gain_stage u_stage6 (
    .mclk      (mclk),
    .rst       (rst),
    .smp_in    (stage5_out),
    .gain      (final_gain_value_r),
    .smp_out_r (final_out)
  );

  // shared monitor setup and the two watched stage outputs
  assign mon_cfg.enable    = monitor_enable_r;
  assign mon_cfg.above     = monitor_above_r;
  assign mon_cfg.threshold = monitor_threshold_r;
  assign mon_smp[0]        = stage5_out;
  assign mon_smp[1]        = final_out;

  // one threshold counter per monitored stage; both share one setup and
  // one period, so their counts compare directly
  for (genvar i = 0; i < NM; i++) begin : g_mon
    ogpm_thresh_counter u_cnt (
      .mclk        (mclk),
      .rst         (rst),
      .smp         (mon_smp[i]),
      .cfg         (mon_cfg),
      .restart     (monitor_restart_r),
      .window_open (window_r),
      .count_r     (mon_count[i])
    );
  end

  // read decode; unmapped addresses read zero,
  // strobe bits read back only in the cycle they are high
  always_comb begin
    rdata_nxt = ogpm_pkg::REG_ZERO;
    if (reg_addr == ogpm_pkg::ADDR_LOAD_CTRL) begin
      rdata_nxt[ogpm_pkg::LOAD_PULSE_BIT] = freq_word_load_pulse_r;
    end else if (reg_addr == ogpm_pkg::ADDR_GAIN5) begin
      rdata_nxt[ogpm_pkg::GAIN_W-1:0] = stage5_gain_r;
    end else if (reg_addr == ogpm_pkg::ADDR_FREQ_LOW) begin
      rdata_nxt = osc4_freq_word_low_r;
    end else if (reg_addr == ogpm_pkg::ADDR_FREQ_HIGH) begin
      rdata_nxt[ogpm_pkg::FREQ_HIGH_W-1:0] = osc4_freq_word_high_r;
    end else if (reg_addr == ogpm_pkg::ADDR_STAGE5_CNT) begin
      rdata_nxt[ogpm_pkg::COUNT_W-1:0] = mon_count[0];
    end else if (reg_addr == ogpm_pkg::ADDR_MON_CTRL) begin
      rdata_nxt[ogpm_pkg::THRESH_LSB +: ogpm_pkg::THRESH_W] = monitor_threshold_r;
      rdata_nxt[ogpm_pkg::MON_ENABLE_BIT] = monitor_enable_r;
      rdata_nxt[ogpm_pkg::MON_MODE_BIT]   = monitor_above_r;
      rdata_nxt[ogpm_pkg::MON_RESET_BIT]  = monitor_restart_r;
    end else if (reg_addr == ogpm_pkg::ADDR_TIMER_LOW) begin
      rdata_nxt = start_count_r[15:0];
    end else if (reg_addr == ogpm_pkg::ADDR_TIMER_MID) begin
      rdata_nxt = start_count_r[31:16];
    end else if (reg_addr == ogpm_pkg::ADDR_TIMER_HIGH) begin
      rdata_nxt = start_count_r[47:32];
    end else if (reg_addr == ogpm_pkg::ADDR_FINAL_GAIN_SETTING) begin
      rdata_nxt[ogpm_pkg::GAIN_W-1:0] = final_gain_value_r;
    end else if (reg_addr == ogpm_pkg::ADDR_STAGE6_CNT) begin
      rdata_nxt[ogpm_pkg::COUNT_W-1:0] = mon_count[1];
    end
  end

  // read data stands only in the cycle after the strobe and drops
  // to zero after, so stale data is never mistaken for a new answer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= '0;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end else begin
      reg_rdata_r <= '0;
    end
  end

endmodule : ogpm_top

/* File: verif/ogpm_top_chk.sv */
`timescale 1ns/1ps
module ogpm_top_chk (
  // clock and reset
  input wire logic                          mclk,
  input wire logic                          rst,
  // register port
  input wire logic [7:0]                    reg_addr,
  input wire logic [15:0]                   reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [15:0]                   reg_rdata_r,
  // sample path
  input wire ogpm_pkg::ogpm_sample_s        combiner_in,
  input wire ogpm_pkg::ogpm_sample_s        final_out,
  // frequency and monitor
  input wire logic [20:0]                   osc4_frequency_word_r,
  input wire logic                          osc4_freq_sign_r,
  input wire logic [19:0]                   osc4_freq_magnitude_r,
  input wire logic signed [20:0]            osc4_freq_step_r,
  input wire logic                          osc4_freq_update_r,
  input wire logic                          monitor_busy_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // bus requests that start multi-cycle answers
  sequence s_load_wr;
    reg_wr && reg_addr == ogpm_pkg::ADDR_LOAD_CTRL && reg_wdata[0];
  endsequence
  sequence s_rd_cnt;
    reg_rd && (reg_addr == ogpm_pkg::ADDR_STAGE5_CNT || reg_addr == ogpm_pkg::ADDR_STAGE6_CNT);
  endsequence

  AST_LOAD_TO_UPDATE: assert property (s_load_wr |-> ##2 osc4_freq_update_r)
    else $error("load write gave no update two cycles later");
  AST_UPDATE_CAUSE: assert property (osc4_freq_update_r |-> $past(reg_wr, 2))
    else $error("update pulse without a load write");
  AST_WORD_HOLD: assert property (!osc4_freq_update_r |-> $stable(osc4_frequency_word_r))
    else $error("frequency word moved without update");
  AST_SIGN_BIT: assert property (osc4_freq_sign_r == osc4_frequency_word_r[20])
    else $error("sign is not word bit 20");
  AST_MAG_BITS: assert property (osc4_freq_magnitude_r == osc4_frequency_word_r[19:0])
    else $error("magnitude is not word bits 19..0");
  AST_STEP_VALUE: assert property (osc4_freq_step_r == (osc4_freq_sign_r ?
      -$signed({1'b0, osc4_freq_magnitude_r}) : $signed({1'b0, osc4_freq_magnitude_r})))
    else $error("signed step does not match sign and magnitude");
  AST_CNT_WIDTH: assert property (s_rd_cnt |=> reg_rdata_r[15:12] == 4'h0)
    else $error("monitor count wider than 12 bits");
  AST_GAIN_WIDTH: assert property (reg_rd && reg_addr == ogpm_pkg::ADDR_FINAL_GAIN_SETTING
      |=> reg_rdata_r[15:9] == 7'h00)
    else $error("final gain wider than 9 bits");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_r == 16'h0000)
    else $error("read data outside its read slot");
  AST_PIPE_VALID: assert property (combiner_in.valid |-> ##2 final_out.valid)
    else $error("sample lost in gain stages");
endmodule : ogpm_top_chk

bind ogpm_top ogpm_top_chk u_chk (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .combiner_in(combiner_in),
  .final_out(final_out), .osc4_frequency_word_r(osc4_frequency_word_r),
  .osc4_freq_sign_r(osc4_freq_sign_r), .osc4_freq_magnitude_r(osc4_freq_magnitude_r),
  .osc4_freq_step_r(osc4_freq_step_r), .osc4_freq_update_r(osc4_freq_update_r),
  .monitor_busy_r(monitor_busy_r)
);

/* File: verif/tb_output_gain_power_monitor.sv */
`timescale 1ns/1ps
module tb_output_gain_power_monitor;
  typedef struct packed {
    logic [7:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } ogpm_tb_row_s;

  logic                  mclk = 1'b0;
  logic                  rst  = 1'b1;
  logic [7:0]            reg_addr = 8'h00;
  logic [15:0]           reg_wdata = 16'h0000;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [15:0]           reg_rdata_r;
  ogpm_pkg::ogpm_sample_s combiner_in = '0;
  ogpm_pkg::ogpm_sample_s final_out;
  logic [20:0]           freq_word;
  logic                  freq_sign;
  logic [19:0]           freq_mag;
  logic signed [20:0]    freq_step;
  logic                  freq_upd;
  logic                  busy;
  logic [15:0]           v;
  int                    num_errors = 0;
  int                    n_checks = 0;
  ogpm_tb_row_s          rows [10];

  // 250 MHz clock
  always #2 mclk = ~mclk;

  ogpm_top dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .combiner_in(combiner_in), .final_out(final_out),
    .osc4_frequency_word_r(freq_word), .osc4_freq_sign_r(freq_sign),
    .osc4_freq_magnitude_r(freq_mag), .osc4_freq_step_r(freq_step),
    .osc4_freq_update_r(freq_upd), .monitor_busy_r(busy)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, released at the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data only stands in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_r;
  endtask : rd

  // restart a monitor period, check busy tmr + 6 cycles after it rises, then read both counters
  task automatic mon(input logic [15:0] data, input logic [15:0] cfg, input logic [15:0] tmr,
                     input logic [15:0] e5, input logic [15:0] e6);
    @(posedge mclk);
    combiner_in <= '{valid: 1'b1, data: data};
    wr(8'h47, tmr);
    wr(8'h46, cfg);
    repeat (2) @(posedge mclk);
    #1 chk(busy, 32'h1);
    repeat (int'(tmr) + 6) @(posedge mclk);
    #1 chk(busy, {31'h0, !cfg[2]});
    rd(8'h44, v);
    chk(v, e5);
    rd(8'h51, v);
    chk(v, e6);
  endtask : mon

  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // watchdog sized well past the longest monitor period
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end

  initial begin
    rows = '{'{8'h42, 16'h1234, 16'h1234}, '{8'h43, 16'hFFFF, 16'h001F},
             '{8'h47, 16'hABCD, 16'hABCD}, '{8'h48, 16'h5A5A, 16'h5A5A},
             '{8'h49, 16'hA5A5, 16'hA5A5}, '{8'h50, 16'hFFFF, 16'h01FF},
             '{8'h44, 16'hFFFF, 16'h0000}, '{8'h51, 16'hFFFF, 16'h0000},
             '{8'h46, 16'hE006, 16'hE006}, '{8'h3F, 16'hFFFF, 16'h0000}};
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h50, v);
    chk(v, 16'h0100);
    rd(8'h51, v);
    chk(v, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    // staged words stay hidden until the load pulse
    chk(freq_word, 32'h0);
    wr(8'h40, 16'h0001);
    @(posedge mclk);
    #1 chk(freq_upd, 32'h1);
    chk(freq_word, 32'h001F1234);
    chk(freq_step, 32'hFFF0EDCC);
    chk(freq_sign, 32'h1);
    chk(freq_mag, 32'h000F1234);
    wr(8'h43, 16'h0005);
    wr(8'h40, 16'h0001);
    @(posedge mclk);
    #1 chk(freq_step, 32'h00051234);
    // final gain: half, then unity, on a fixed sample
    wr(8'h48, 16'h0000);
    wr(8'h49, 16'h0000);
    wr(8'h50, 16'h0080);
    combiner_in <= '{valid: 1'b1, data: 16'h4000};
    repeat (4) @(posedge mclk);
    #1 chk(final_out.data, 32'h1FE0);
    chk(final_out.valid, 32'h1);
    wr(8'h50, 16'h0100);
    repeat (4) @(posedge mclk);
    #1 chk(final_out.data, 32'h3FC0);
    // above, below, negative pairing, disabled, saturation
    mon(16'h4000, 16'h2007, 16'h000A, 16'h000A, 16'h000A);
    mon(16'h4000, 16'h2005, 16'h000A, 16'h0000, 16'h0000);
    mon(16'hC000, 16'hE005, 16'h000A, 16'h000A, 16'h000A);
    mon(16'hC000, 16'hE001, 16'h000A, 16'h0000, 16'h0000);
    mon(16'h4000, 16'h2007, 16'h1400, 16'h0FFF, 16'h0FFF);
    give_verdict();
  end
endmodule : tb_output_gain_power_monitor
